/* rtl/i2cfm_pkg.sv */
// i2cfm_pkg: shared constants and state type of the serial memory slave
// assumes: included before rtl/i2cfm_slave.sv; nothing else depends on it
package i2cfm_pkg;
   // memory geometry
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned MEM_DEPTH = 8192;
   localparam int unsigned BYTE_W = 8;
   // width of the upper word address byte that is kept
   localparam int unsigned WHI_W = ADDR_W - BYTE_W;
   // bit counter values inside one nine-clock slot
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // slave address byte fields
   localparam int unsigned TYPE_MSB = 7;
   localparam int unsigned TYPE_LSB = 4;
   localparam int unsigned SEL_MSB = 3;
   localparam int unsigned SEL_LSB = 1;
   localparam int unsigned DIR_BIT = 0;
   localparam logic DIR_READ = 1'b1;
   // high-speed master code: upper five bits 00001, lower three free
   localparam int unsigned MCODE_LSB = 3;
   localparam logic [4:0] MASTER_CODE = 5'h01;
   // synchroniser bundle layout
   localparam int unsigned SY_SCL = 0;
   localparam int unsigned SY_SDA = 1;
   localparam int unsigned SY_TOG = 2;
   localparam int unsigned SY_SEL_LSB = 3;
   localparam int unsigned SY_SEL_MSB = 5;
   localparam int unsigned SY_WP = 6;
   localparam int unsigned SY_W = 7;
   // reset values
   localparam logic [SY_W-1:0] SY_RST = 7'h00;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [WHI_W-1:0] WHI_RST = 5'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WHI   = 3'b010,
      ST_WLO   = 3'b011,
      ST_WDATA = 3'b100,
      ST_RDATA = 3'b101,
      ST_WAIT  = 3'b110
   } i2cfm_state_t;
endpackage

/* rtl/i2cfm_slave.sv */
// i2cfm_slave: two-wire slave front end and sequencer of an 8192 x 8 memory
// assumes: clk_i well above the serial clock (each scl phase lasts several clk_i
// periods); scl_i clocks only the bit sampler; an external pull-up resolves sda.
`timescale 1ns/1ns
`default_nettype none

module i2cfm_slave #(
   // device type code; the default value is arbitrary
   parameter logic [3:0] TYPE_CODE = 4'h5,
   parameter int unsigned ADDR_W = i2cfm_pkg::ADDR_W,
   parameter int unsigned MEM_DEPTH = i2cfm_pkg::MEM_DEPTH
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [2:0] device_select_pins_i,
   input wire logic wp_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic hs_mode_o,
   output logic busy_o
);

   // link domain: bit sampler
   logic cap_bit_q;
   logic cap_tog_q;
   // system domain: synchronisers and history
   logic [i2cfm_pkg::SY_W-1:0] sync_m_q;
   logic [i2cfm_pkg::SY_W-1:0] sync_s_q;
   logic [2:0] hist_q;
   // sequencer state
   i2cfm_pkg::i2cfm_state_t state_q;
   logic [3:0] bitcnt_q;
   logic [i2cfm_pkg::BYTE_W-1:0] shift_q;
   logic ack_q;
   logic [i2cfm_pkg::WHI_W-1:0] whi_q;
   logic [ADDR_W-1:0] addr_q;
   logic [i2cfm_pkg::BYTE_W-1:0] tx_q;
   logic [i2cfm_pkg::BYTE_W-1:0] mem [MEM_DEPTH];
   // decoded events
   logic scl_s;
   logic sda_s;
   logic tog_s;
   logic scl_p;
   logic sda_p;
   logic tog_p;
   logic [2:0] sel_s;
   logic wp_s;
   logic start_ev;
   logic stop_ev;
   logic rise_ev;
   logic fall_ev;
   logic active;
   logic byte_done;
   logic ack_slot;
   logic load_tx;
   logic [i2cfm_pkg::BYTE_W-1:0] byte_in;
   logic addr_match;
   logic is_mcode;
   logic tx_bit;
   logic drive_d;

   // link domain: sample sda on every rising scl, toggle marks a new bit
   // cap_bit_q is read on the system side only after the toggle has crossed,
   // and it stands for the whole scl high phase, so it needs no synchroniser
   always_ff @(posedge scl_i)
   begin
      cap_bit_q <= sda_i;
   end

   // toggle cleared by reset even while scl stands still
   always_ff @(posedge scl_i or posedge srst_i)
   begin
      if (srst_i)
      begin
         cap_tog_q <= 1'b0;
      end
      else
      begin
         cap_tog_q <= ~cap_tog_q;
      end
   end

   // two-stage synchronisers for pins and the bit toggle, then one history stage
   // scl and sda share one bundle so both are seen in the same clk_i cycle
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sync_m_q <= i2cfm_pkg::SY_RST;
         sync_s_q <= i2cfm_pkg::SY_RST;
         hist_q <= 3'h0;
      end
      else
      begin
         sync_m_q <= {wp_i, device_select_pins_i, cap_tog_q, sda_i, scl_i};
         sync_s_q <= sync_m_q;
         hist_q <= sync_s_q[i2cfm_pkg::SY_TOG:i2cfm_pkg::SY_SCL];
      end
   end

   // synchronised levels
   assign scl_s = sync_s_q[i2cfm_pkg::SY_SCL];
   assign sda_s = sync_s_q[i2cfm_pkg::SY_SDA];
   assign tog_s = sync_s_q[i2cfm_pkg::SY_TOG];
   assign sel_s = sync_s_q[i2cfm_pkg::SY_SEL_MSB:i2cfm_pkg::SY_SEL_LSB];
   assign wp_s = sync_s_q[i2cfm_pkg::SY_WP];
   assign scl_p = hist_q[i2cfm_pkg::SY_SCL];
   assign sda_p = hist_q[i2cfm_pkg::SY_SDA];
   assign tog_p = hist_q[i2cfm_pkg::SY_TOG];

   // bus conditions and clock edges
   // both need scl high in two stages in a row, and the master moves sda well
   // after scl falls, so a data change is never taken for a start or stop
   assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
   assign rise_ev = tog_s ^ tog_p;
   assign fall_ev = scl_p & ~scl_s;

   // slot strobes; start and stop always take precedence
   assign active = (state_q != i2cfm_pkg::ST_IDLE) && (state_q != i2cfm_pkg::ST_WAIT);
   assign byte_done = rise_ev & ~start_ev & ~stop_ev & active
                      & (bitcnt_q == i2cfm_pkg::BIT_LAST) & (state_q != i2cfm_pkg::ST_RDATA);
   assign ack_slot = rise_ev & ~start_ev & ~stop_ev & active & (bitcnt_q == i2cfm_pkg::ACK_SLOT);
   assign byte_in = {shift_q[i2cfm_pkg::BYTE_W-2:0], cap_bit_q};

   // address byte decode
   assign addr_match = (byte_in[i2cfm_pkg::TYPE_MSB:i2cfm_pkg::TYPE_LSB] == TYPE_CODE)
                       && (byte_in[i2cfm_pkg::SEL_MSB:i2cfm_pkg::SEL_LSB] == sel_s);
   assign is_mcode = byte_in[i2cfm_pkg::BYTE_W-1:i2cfm_pkg::MCODE_LSB] == i2cfm_pkg::MASTER_CODE;

   // a read byte is fetched after our address ack or after a master ack
   // each fetch also advances the counter, so a later current read goes on
   // from one past the last byte sent
   assign load_tx = ack_slot & (state_q == i2cfm_pkg::ST_RDATA) & (ack_q | ~cap_bit_q);

   // sequencer: bit counting, byte decode and command flow
   // a repeated start or stop raises scl once more and counts one bit; the
   // condition that follows clears the counter before any data bit arrives
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_q <= i2cfm_pkg::ST_IDLE;
         bitcnt_q <= i2cfm_pkg::BIT_FIRST;
         shift_q <= i2cfm_pkg::BYTE_RST;
         ack_q <= 1'b0;
      end
      else if (start_ev)
      begin
         // a repeated start keeps the address counter
         state_q <= i2cfm_pkg::ST_ADDR;
         bitcnt_q <= i2cfm_pkg::BIT_FIRST;
         ack_q <= 1'b0;
      end
      else if (stop_ev)
      begin
         state_q <= i2cfm_pkg::ST_IDLE;
         bitcnt_q <= i2cfm_pkg::BIT_FIRST;
         ack_q <= 1'b0;
      end
      else if (ack_slot)
      begin
         bitcnt_q <= i2cfm_pkg::BIT_FIRST;
         ack_q <= 1'b0;
         if ((state_q == i2cfm_pkg::ST_RDATA) && !ack_q && cap_bit_q)
         begin
            state_q <= i2cfm_pkg::ST_WAIT;
         end
      end
      else if (rise_ev && active)
      begin
         shift_q <= byte_in;
         bitcnt_q <= bitcnt_q + 4'h1;
         if (byte_done)
         begin
            unique case (state_q)
               i2cfm_pkg::ST_ADDR:
               begin
                  if (is_mcode)
                  begin
                     state_q <= i2cfm_pkg::ST_WAIT;
                  end
                  else if (addr_match)
                  begin
                     ack_q <= 1'b1;
                     if (byte_in[i2cfm_pkg::DIR_BIT] == i2cfm_pkg::DIR_READ)
                     begin
                        state_q <= i2cfm_pkg::ST_RDATA;
                     end
                     else
                     begin
                        state_q <= i2cfm_pkg::ST_WHI;
                     end
                  end
                  else
                  begin
                     state_q <= i2cfm_pkg::ST_WAIT;
                  end
               end
               i2cfm_pkg::ST_WHI:
               begin
                  ack_q <= 1'b1;
                  state_q <= i2cfm_pkg::ST_WLO;
               end
               i2cfm_pkg::ST_WLO:
               begin
                  ack_q <= 1'b1;
                  state_q <= i2cfm_pkg::ST_WDATA;
               end
               i2cfm_pkg::ST_WDATA:
               begin
                  ack_q <= 1'b1;
               end
               default:
               begin
                  ack_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // high-speed flag: set by the master code, held until stop
   // set and clear never meet: byte_done already excludes a stop cycle
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         hs_mode_o <= 1'b0;
      end
      else if (stop_ev)
      begin
         hs_mode_o <= 1'b0;
      end
      else if (byte_done && (state_q == i2cfm_pkg::ST_ADDR) && is_mcode)
      begin
         hs_mode_o <= 1'b1;
      end
   end

   // upper word address byte, only the bits that reach the array
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         whi_q <= i2cfm_pkg::WHI_RST;
      end
      else if (byte_done && (state_q == i2cfm_pkg::ST_WHI))
      begin
         whi_q <= byte_in[i2cfm_pkg::WHI_W-1:0];
      end
   end

   // address counter, left unreset so its power-up value is arbitrary
   // a current read issued before any addressed access returns an arbitrary byte
   always_ff @(posedge clk_i)
   begin
      if (byte_done && (state_q == i2cfm_pkg::ST_WLO))
      begin
         addr_q <= {whi_q, byte_in};
      end
      else if ((byte_done && (state_q == i2cfm_pkg::ST_WDATA)) || load_tx)
      begin
         addr_q <= ADDR_W'(addr_q + 1'b1);
      end
   end

   // memory array: store unless the write guard is high
   // a guarded byte is still acknowledged and still advances the counter
   always_ff @(posedge clk_i)
   begin
      if (byte_done && (state_q == i2cfm_pkg::ST_WDATA) && !wp_s)
      begin
         mem[addr_q] <= byte_in;
      end
   end

   // transmit byte fetched from the current address
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         tx_q <= i2cfm_pkg::BYTE_RST;
      end
      else if (load_tx)
      begin
         tx_q <= mem[addr_q];
      end
   end

   // value to present after the next falling scl
   assign tx_bit = tx_q[3'(i2cfm_pkg::BIT_LAST - bitcnt_q)];
   assign drive_d = ((bitcnt_q == i2cfm_pkg::ACK_SLOT) && ack_q)
                    || ((state_q == i2cfm_pkg::ST_RDATA) && !ack_q
                        && (bitcnt_q != i2cfm_pkg::ACK_SLOT) && !tx_bit);

   // open-drain pull-down, updated on falling scl and released at start or stop
   // limitation: scl phases shorter than about five clk_i periods are missed,
   // so the high-speed flag is kept but high-speed rates are not met
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sda_oe_o <= 1'b0;
      end
      else if (start_ev || stop_ev)
      begin
         sda_oe_o <= 1'b0;
      end
      else if (fall_ev)
      begin
         sda_oe_o <= drive_d;
      end
   end

   // output level is always low; only the enable moves
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sda_o <= 1'b0;
      end
      else
      begin
         sda_o <= 1'b0;
      end
   end

   // busy while a command is in progress
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         busy_o <= 1'b0;
      end
      else
      begin
         busy_o <= state_q != i2cfm_pkg::ST_IDLE;
      end
   end

endmodule

`default_nettype wire

/* testbench/i2cfm_properties.sv */
// i2cfm_props: port assertions for the serial memory slave
// assumes: bound to i2cfm_slave; each scl phase lasts several clk_i periods
`timescale 1ns/1ns
`default_nettype none
module i2cfm_props (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [2:0] device_select_pins_i,
   input wire logic wp_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic hs_mode_o,
   input wire logic busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // bus conditions and the next clock pulse as seen at clk_i
   sequence s_start;
      scl_i && $past(scl_i) && $fell(sda_i);
   endsequence
   sequence s_stop;
      scl_i && $past(scl_i) && $rose(sda_i);
   endsequence
   sequence s_next_rise;
      ##[1:30] $rose(scl_i);
   endsequence
   a_sda_low_only: assert property (sda_o == 1'b0)
      else $error("sda output level not low");
   a_drive_after_fall: assert property ($rose(sda_oe_o) |-> !scl_i && $past(scl_i, 2) == 1'b0)
      else $error("sda drive began outside scl low");
   a_hold_scl_high: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*5])
      else $error("sda drive changed while scl high");
   a_hs_no_ack: assert property ($rose(hs_mode_o) |-> !sda_oe_o throughout s_next_rise)
      else $error("master code byte acknowledged");
   a_hs_until_stop: assert property ($fell(hs_mode_o) |-> $past(scl_i, 2) && sda_i)
      else $error("speed flag dropped without stop");
   a_stop_idles: assert property (s_stop |-> ##[1:6] !busy_o)
      else $error("busy after stop");
   a_start_busy: assert property (s_start |-> ##[1:6] busy_o)
      else $error("start not taken");
   a_drive_needs_busy: assert property (sda_oe_o |-> busy_o)
      else $error("sda driven while idle");
endmodule
bind i2cfm_slave i2cfm_props i_i2cfm_props (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i),
   .sda_i(sda_i), .device_select_pins_i(device_select_pins_i), .wp_i(wp_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .hs_mode_o(hs_mode_o), .busy_o(busy_o));
`default_nettype wire

/* testbench/i2cfm_master.sv */
// i2cfm_master: behavioural two-wire bus master
// assumes: sda_i is the resolved wire with pull-up; scl stands high between frames
`timescale 1ns/1ns
`default_nettype none
module i2cfm_master #(
   parameter int T = 307
) (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // bus idle at time zero
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // start or repeated start, sda moves a quarter phase after scl falls
   task automatic start();
      #(T/4);
      sda_pull_o = 1'b0;
      #T;
      scl_o = 1'b1;
      #T;
      sda_pull_o = 1'b1;
      #T;
      scl_o = 1'b0;
   endtask
   // stop, then the clock stands high
   task automatic stop();
      #(T/4);
      sda_pull_o = 1'b1;
      #T;
      scl_o = 1'b1;
      #T;
      sda_pull_o = 1'b0;
      #T;
   endtask
   // eight bits msb first and the ninth clock; a is the level left in slot nine
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
      logic [8:0] s;
      s = {d, a};
      for (int i = 8; i >= 0; i--)
      begin
         #(T/4);
         sda_pull_o = !s[i];
         #(T-T/4);
         scl_o = 1'b1;
         #(T/2);
         if (i > 0)
            q[i-1] = sda_i;
         else
            ack = sda_i;
         #(T/2);
         scl_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* testbench/test_i2c_nonvolatile_memory_slave.sv */
// test_i2c_nonvolatile_memory_slave: self-checking bench with a memory model
// assumes: i2cfm_master drives the bus; i2cfm_props is bound to the design
`timescale 1ns/1ns
`default_nettype none
module test_i2c_nonvolatile_memory_slave;
   localparam logic [3:0] TC = 4'h6; // type code, arbitrary value
   logic clk_i, srst_i, wp_i, scl, pull, oe, sdo, hs, busy, ack;
   logic [2:0] sel;
   logic [7:0] q;
   logic [7:0] mem [int];
   int err_total, n_checks, cnt;
   wire sda;
   assign sda = !(oe || pull); // pull-up wire
   i2cfm_slave #(.TYPE_CODE(TC)) i_i2cfm_slave (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl),
      .sda_i(sda), .device_select_pins_i(sel), .wp_i(wp_i), .sda_o(sdo), .sda_oe_o(oe),
      .hs_mode_o(hs), .busy_o(busy));
   i2cfm_master i_i2cfm_master (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
   // 50 ns system clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = !clk_i;
   end
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic x(input logic [7:0] d, input logic a);
      i_i2cfm_master.xfer(d, a, q, ack);
   endtask
   // start, select byte, then the word address when a is not negative
   task automatic head(input logic rd, input int a);
      i_i2cfm_master.start();
      x({TC, sel, rd}, 1'b1);
      chk({7'h00, ack}, 8'h00);
      if (a >= 0)
      begin
         x({3'h7, a[12:8]}, 1'b1);
         chk({7'h00, ack}, 8'h00);
         x(a[7:0], 1'b1);
         chk({7'h00, ack}, 8'h00);
         cnt = a;
      end
   endtask
   // write n random bytes from address a
   task automatic wr(input int a, input int n);
      logic [7:0] d;
      head(1'b0, a);
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         x(d, 1'b1);
         chk({7'h00, ack}, 8'h00);
         if (!wp_i)
            mem[cnt] = d;
         cnt = (cnt + 1) % 8192;
      end
      i_i2cfm_master.stop();
      chk({7'h00, busy}, 8'h00);
      chk({7'h00, sdo}, 8'h00);
   endtask
   // read n bytes, from a or from the counter, nack on the last
   task automatic rdn(input int a, input int n);
      if (a >= 0)
         head(1'b0, a);
      head(1'b1, -1);
      for (int i = 0; i < n; i++)
      begin
         x(8'hff, i == n - 1);
         chk(q, mem[cnt]);
         cnt = (cnt + 1) % 8192;
      end
      i_i2cfm_master.stop();
   endtask
   // main sequence
   initial
   begin
      void'($urandom(27));
      err_total = 0;
      n_checks = 0;
      cnt = 0;
      srst_i = 1'b0;
      wp_i = 1'b0;
      sel = 3'h0;
      // raise reset after time zero so the scl-side toggle surely sees its edge
      #1;
      srst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      sel <= 3'($urandom);
      repeat (4) @(posedge clk_i);
      wr(8190, 4);
      rdn(8190, 3);
      rdn(-1, 1);
      $display("test write and read done");
      @(posedge clk_i);
      wp_i <= 1'b1; // steady over the command
      repeat (4) @(posedge clk_i);
      wr(0, 2);
      @(posedge clk_i);
      wp_i <= 1'b0;
      rdn(0, 2);
      $display("test guarded write done");
      for (int k = 0; k < 2; k++)
      begin
         i_i2cfm_master.start();
         x({TC ^ {3'h0, k == 0}, sel ^ {2'h0, k == 1}, 1'b0}, 1'b1);
         chk({7'h00, ack}, 8'h01);
         i_i2cfm_master.stop();
      end
      $display("test foreign address done");
      i_i2cfm_master.start();
      x({5'h01, 3'($urandom)}, 1'b1);
      chk({7'h00, ack}, 8'h01);
      chk({7'h00, hs}, 8'h01);
      wr(5, 1);
      chk({7'h00, hs}, 8'h00);
      rdn(5, 1);
      $display("test speed mode done");
      test_done();
   end
   // watchdog: over twelve times the expected bus traffic
   initial
   begin
      #3000000;
      err_total++;
      test_done();
   end
endmodule
`default_nettype wire
